// ===== verilog/smcs_stop_seq.sv
// smcs_stop_seq: stop-mode entry/exit sequencing of a clock and reset generator
// assumes all inputs except the asynchronous reset_n_in synchronous to mclk_in; clock gates and enables are outputs
`timescale 1ns/1ns
`default_nettype none
module smcs_stop_seq #(
  parameter int CHECK_CYCLES = int'(smcs_pkg::SMCS_CHECK_WINDOW)
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic stop_req_in,
  input wire logic wake_irq_in,
  input wire logic pseudo_stop_select_in,
  input wire logic watchdog_in_pseudo_stop_enable_in,
  input wire logic tick_in_pseudo_stop_enable_in,
  input wire logic fast_wake_enable_in,
  input wire logic self_clock_mode_enable_in,
  input wire logic self_clock_mode_in,
  input wire logic loop_clock_select_set_in,
  input wire logic loop_clock_select_clr_in,
  input wire logic self_clock_mode_flag_clr_in,
  input wire logic osc_good_in,
  output logic loop_clock_select_out,
  output logic pll_enable_out,
  output logic core_clock_enable_out,
  output logic system_clock_enable_out,
  output logic oscillator_enable_out,
  output logic clock_monitor_enable_out,
  output logic quality_check_active_out,
  output logic periodic_tick_timer_run_out,
  output logic watchdog_run_out,
  output logic voltage_regulator_low_power_out,
  output logic self_clock_active_out,
  output logic self_clock_mode_flag_out
);
  // elaboration guard: the window counter is 16 bits wide
  initial
  begin
    if (CHECK_CYCLES < 1 || CHECK_CYCLES > 65535)
      $error("CHECK_CYCLES out of range");
  end

  smcs_pkg::smcs_state_t state_q, state_d;
  logic pstop_q;
  logic from_scm_q;
  logic [15:0] chk_cnt_q;
  logic sel_q, flag_q;
  logic check_done;
  logic chk_run;

  // check passes when oscillator is good and the window elapses
  assign check_done = osc_good_in && (chk_cnt_q == 16'(CHECK_CYCLES));
  // quality check runs in check state, or in pseudo stop entered from self-clock
  assign chk_run = (state_q == smcs_pkg::SMCS_CHECK) ||
                   (state_q == smcs_pkg::SMCS_STOPPED && pstop_q && from_scm_q);

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      smcs_pkg::SMCS_RUN: if (stop_req_in) state_d = smcs_pkg::SMCS_DESEL;
      smcs_pkg::SMCS_DESEL: state_d = smcs_pkg::SMCS_PLL_OFF;
      smcs_pkg::SMCS_PLL_OFF: state_d = smcs_pkg::SMCS_CORE_OFF;
      smcs_pkg::SMCS_CORE_OFF: state_d = smcs_pkg::SMCS_STOPPED;
      smcs_pkg::SMCS_STOPPED:
        if (wake_irq_in)
        begin
          if (!pstop_q && fast_wake_enable_in && self_clock_mode_enable_in)
            state_d = smcs_pkg::SMCS_FAST_SCM;
          else if (!pstop_q && from_scm_q)
            state_d = smcs_pkg::SMCS_CHECK;
          else
            state_d = smcs_pkg::SMCS_RUN;
        end
      smcs_pkg::SMCS_FAST_SCM: if (!fast_wake_enable_in) state_d = smcs_pkg::SMCS_CHECK;
      smcs_pkg::SMCS_CHECK: if (check_done) state_d = smcs_pkg::SMCS_RUN;
      default: state_d = smcs_pkg::SMCS_RUN;
    endcase
  end

  // state, entry context; async reset restarts the normal start-up path
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= smcs_pkg::SMCS_RUN;
      pstop_q <= 1'b0;
      from_scm_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == smcs_pkg::SMCS_RUN && stop_req_in)
      begin
        pstop_q <= pseudo_stop_select_in;
        from_scm_q <= self_clock_mode_in;
      end
    end
  end

  // check window counter, aborted and cleared whenever the check is not running
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      chk_cnt_q <= 16'h0000;
    else if (!chk_run || !osc_good_in)
      chk_cnt_q <= 16'h0000;
    else if (chk_cnt_q != 16'(CHECK_CYCLES))
      chk_cnt_q <= chk_cnt_q + 16'h0001;
  end

  // loop clock select: cleared on stop entry, set only by software
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      sel_q <= smcs_pkg::RST_LOOP_SEL;
    else if (state_q == smcs_pkg::SMCS_DESEL)
      sel_q <= 1'b0;
    else if (state_q == smcs_pkg::SMCS_RUN && loop_clock_select_set_in && !stop_req_in)
      sel_q <= 1'b1;
    else if (loop_clock_select_clr_in)
      sel_q <= 1'b0;
  end

  // self-clock flag: set by a successful check in the check state, after fast wake or full stop from self-clock; set wins over clear
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      flag_q <= smcs_pkg::RST_SCM_FLAG;
    else if (state_q == smcs_pkg::SMCS_CHECK && check_done)
      flag_q <= 1'b1;
    else if (self_clock_mode_flag_clr_in)
      flag_q <= 1'b0; // fast wake itself never sets it
  end

  // registered outputs
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pll_enable_out <= 1'b1;
      core_clock_enable_out <= 1'b1;
      system_clock_enable_out <= 1'b1;
      oscillator_enable_out <= 1'b1;
      clock_monitor_enable_out <= 1'b1;
      quality_check_active_out <= 1'b0;
      periodic_tick_timer_run_out <= 1'b1;
      watchdog_run_out <= 1'b1;
      voltage_regulator_low_power_out <= 1'b0;
      self_clock_active_out <= 1'b0;
    end
    else
    begin
      pll_enable_out <= (state_d == smcs_pkg::SMCS_RUN) ||
                        (state_d == smcs_pkg::SMCS_DESEL) ||
                        (state_d == smcs_pkg::SMCS_CHECK) ||
                        (state_d == smcs_pkg::SMCS_FAST_SCM) ||
                        ((state_d == smcs_pkg::SMCS_PLL_OFF ||
                          state_d == smcs_pkg::SMCS_CORE_OFF ||
                          state_d == smcs_pkg::SMCS_STOPPED) && pstop_q && from_scm_q);
      core_clock_enable_out <= (state_d == smcs_pkg::SMCS_RUN) ||
                               (state_d == smcs_pkg::SMCS_DESEL) ||
                               (state_d == smcs_pkg::SMCS_PLL_OFF) ||
                               (state_d == smcs_pkg::SMCS_FAST_SCM) ||
                               (state_d == smcs_pkg::SMCS_CHECK);
      system_clock_enable_out <= (state_d != smcs_pkg::SMCS_STOPPED);
      oscillator_enable_out <= !(state_d == smcs_pkg::SMCS_FAST_SCM ||
                                 (state_d == smcs_pkg::SMCS_STOPPED && !pstop_q));
      clock_monitor_enable_out <= !(state_d == smcs_pkg::SMCS_FAST_SCM ||
                                    (state_d == smcs_pkg::SMCS_STOPPED && !pstop_q));
      quality_check_active_out <= (state_d == smcs_pkg::SMCS_CHECK) ||
                                  (state_d == smcs_pkg::SMCS_STOPPED && pstop_q && from_scm_q &&
                                   !check_done); // stops once the check passes
      periodic_tick_timer_run_out <= (state_d != smcs_pkg::SMCS_STOPPED) ||
                                     (pstop_q && tick_in_pseudo_stop_enable_in);
      watchdog_run_out <= (state_d != smcs_pkg::SMCS_STOPPED) ||
                          (pstop_q && watchdog_in_pseudo_stop_enable_in);
      voltage_regulator_low_power_out <= (state_d == smcs_pkg::SMCS_STOPPED) &&
                                         !(pstop_q && from_scm_q);
      self_clock_active_out <= (state_d == smcs_pkg::SMCS_FAST_SCM) ||
                               (state_d == smcs_pkg::SMCS_CHECK);
    end
  end

  assign loop_clock_select_out = sel_q;
  assign self_clock_mode_flag_out = flag_q;

  // assertions
  // stop entry steps: select and loop off, then core off, then system off
  sequence s_loop_off;
    !sel_q && state_q == smcs_pkg::SMCS_PLL_OFF && !pll_enable_out && core_clock_enable_out;
  endsequence
  sequence s_core_off;
    !core_clock_enable_out && system_clock_enable_out;
  endsequence
  property p_pll_seq;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (state_q == smcs_pkg::SMCS_DESEL && !(pstop_q && from_scm_q))
      |-> ##1 s_loop_off ##1 s_core_off ##1 !system_clock_enable_out;
  endproperty
  a_pll_seq: assert property (p_pll_seq) else $error("stop entry order wrong");

  property p_pll_kept;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (state_q != smcs_pkg::SMCS_RUN && pstop_q && from_scm_q) |-> pll_enable_out;
  endproperty
  a_pll_kept: assert property (p_pll_kept) else $error("loop off in self-clock pseudo stop");

  property p_chk_pass;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (state_q == smcs_pkg::SMCS_STOPPED && pstop_q && from_scm_q && check_done)
      |=> !quality_check_active_out;
  endproperty
  a_chk_pass: assert property (p_chk_pass) else $error("check still active after pass");

  property p_osc_full_stop;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (state_q == smcs_pkg::SMCS_STOPPED && !pstop_q) |-> (!oscillator_enable_out && !clock_monitor_enable_out);
  endproperty
  a_osc_full_stop: assert property (p_osc_full_stop) else $error("osc on in full stop");

  property p_fast_wake;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (state_q == smcs_pkg::SMCS_STOPPED && !pstop_q && wake_irq_in && fast_wake_enable_in
     && self_clock_mode_enable_in) |=> (state_q == smcs_pkg::SMCS_FAST_SCM && $stable(flag_q));
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("fast wake path wrong");

  property p_fast_osc_off;
    @(posedge mclk_in) disable iff (!reset_n_in)
    state_q == smcs_pkg::SMCS_FAST_SCM |-> (!oscillator_enable_out && self_clock_active_out);
  endproperty
  a_fast_osc_off: assert property (p_fast_osc_off) else $error("osc on during fast wake");

  property p_fast_exit;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (state_q == smcs_pkg::SMCS_FAST_SCM && !fast_wake_enable_in) |=> (state_q == smcs_pkg::SMCS_CHECK);
  endproperty
  a_fast_exit: assert property (p_fast_exit) else $error("fast wake clear ignored");

  property p_flag_set;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (state_q == smcs_pkg::SMCS_CHECK && check_done) |=> (flag_q && state_q == smcs_pkg::SMCS_RUN);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set after check");

  property p_sel_clear;
    @(posedge mclk_in) disable iff (!reset_n_in)
    state_q == smcs_pkg::SMCS_STOPPED |-> !sel_q;
  endproperty
  a_sel_clear: assert property (p_sel_clear) else $error("loop select set in stop");

  property p_wake_only_irq;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (state_q == smcs_pkg::SMCS_STOPPED && !wake_irq_in) |=> state_q == smcs_pkg::SMCS_STOPPED;
  endproperty
  a_wake_only_irq: assert property (p_wake_only_irq) else $error("stop left without irq");

  property p_voltage_regulator;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (state_q == smcs_pkg::SMCS_STOPPED && $past(state_q) == smcs_pkg::SMCS_STOPPED)
      |-> (voltage_regulator_low_power_out == !(pstop_q && from_scm_q));
  endproperty
  a_voltage_regulator: assert property (p_voltage_regulator) else $error("regulator request wrong");
endmodule
`default_nettype wire

// ===== include/smcs_pkg.sv
// smcs_pkg: constants and state type for the stop-mode clock sequencer
// assumes a single 50 MHz clock and plain control/status ports
package smcs_pkg;
  // state machine, one-hot
  typedef enum logic [6:0] {
    SMCS_RUN = 7'h01,
    SMCS_DESEL = 7'h02,
    SMCS_PLL_OFF = 7'h04,
    SMCS_CORE_OFF = 7'h08,
    SMCS_STOPPED = 7'h10,
    SMCS_FAST_SCM = 7'h20,
    SMCS_CHECK = 7'h40
  } smcs_state_t;
  localparam logic [15:0] SMCS_CHECK_WINDOW = 16'h0FFF; // quality check window in good cycles
  localparam logic RST_SCM_FLAG = 1'b0;
  localparam logic RST_LOOP_SEL = 1'b0;
endpackage

// ===== verification/smcs_osc_model.sv
// smcs_osc_model: behavioural oscillator that reports good after a start-up delay
// assumes the sequencer's oscillator enable is synchronous to mclk_in
`timescale 1ns/1ns
`default_nettype none
module smcs_osc_model (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic oscillator_enable_in,
  output logic osc_good_out
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  // start-up count restarts whenever the oscillator is switched off
  assign cnt_d = !oscillator_enable_in ? 2'h0 : (cnt_q == 2'h3 ? cnt_q : cnt_q + 2'h1);
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_q <= 2'h0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end
  // a stopped oscillator never reports good, so no check can pass on it
  assign osc_good_out = oscillator_enable_in && (cnt_q == 2'h3);
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// testbench: scenario tasks for the stop-mode clock sequencer
// assumes smcs_pkg compiled first; inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic stop = 1'b0, irq = 1'b0, pstop = 1'b0, wdog_en = 1'b0, tick_en = 1'b0, fwe = 1'b0;
  logic self_clock_mode_enable = 1'b0, scm = 1'b0, sel_set = 1'b0, sel_clr = 1'b0, flag_clr = 1'b0;
  wire logic good, sel, pll, core, sys, osc, mon, chk_act, tick, wdog, voltage_regulator, scm_act, flag;
  int fails = 0;
  int n_tests = 0;
  // short check window keeps the quality check quick
  smcs_stop_seq #(.CHECK_CYCLES(8)) dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .stop_req_in(stop), .wake_irq_in(irq), .pseudo_stop_select_in(pstop),
    .watchdog_in_pseudo_stop_enable_in(wdog_en), .tick_in_pseudo_stop_enable_in(tick_en),
    .fast_wake_enable_in(fwe), .self_clock_mode_enable_in(self_clock_mode_enable), .self_clock_mode_in(scm),
    .loop_clock_select_set_in(sel_set), .loop_clock_select_clr_in(sel_clr),
    .self_clock_mode_flag_clr_in(flag_clr), .osc_good_in(good), .loop_clock_select_out(sel),
    .pll_enable_out(pll), .core_clock_enable_out(core), .system_clock_enable_out(sys),
    .oscillator_enable_out(osc), .clock_monitor_enable_out(mon),
    .quality_check_active_out(chk_act), .periodic_tick_timer_run_out(tick),
    .watchdog_run_out(wdog), .voltage_regulator_low_power_out(voltage_regulator),
    .self_clock_active_out(scm_act), .self_clock_mode_flag_out(flag));
  smcs_osc_model osc_model (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .oscillator_enable_in(osc), .osc_good_out(good));
  // free-running 50 MHz clock
  always #10 mclk_in = ~mclk_in;
  // helpers: compare, wait, verdict
  task automatic chk(input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t ns: saw %b, expected %b", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one-cycle stop request, then wait until power-down has settled
  task automatic enter_stop;
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    cyc(4);
  endtask
  task automatic wake;
    irq = 1'b1;
    cyc(1);
    irq = 1'b0;
  endtask
  task automatic clear_flag;
    flag_clr = 1'b1;
    cyc(1);
    flag_clr = 1'b0;
    chk(flag, 1'b0);
  endtask
  // full stop with the loop clock selected: walk the power-down order
  task automatic t_full_stop;
    sel_set = 1'b1;
    cyc(1);
    sel_set = 1'b0;
    chk(sel, 1'b1);
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    cyc(1); // select and loop drop one edge after the deselect state
    chk(sel, 1'b0);
    chk(core, 1'b1);
    chk(pll, 1'b0);
    cyc(1);
    chk(core, 1'b0);
    chk(sys, 1'b1);
    cyc(1);
    chk(sys, 1'b0);
    chk(osc, 1'b0);
    chk(mon, 1'b0);
    chk(voltage_regulator, 1'b1);
    chk(wdog, 1'b0);
    cyc(6);
    chk(sys, 1'b0);
    wake();
    chk(sys, 1'b1);
    chk(core, 1'b1);
    chk(sel, 1'b0);
    chk(voltage_regulator, 1'b0);
  endtask
  // pseudo stop outside self-clock keeps the oscillator, the clock monitor and the enabled timers only
  task automatic t_pseudo;
    pstop = 1'b1;
    wdog_en = 1'b1;
    enter_stop();
    chk(osc, 1'b1);
    chk(wdog, 1'b1);
    chk(tick, 1'b0);
    chk(core, 1'b0);
    tick_en = 1'b1;
    cyc(2);
    chk(tick, 1'b1);
    sel_set = 1'b1; // software set is refused while stopped
    cyc(1);
    sel_set = 1'b0;
    chk(sel, 1'b0);
    wake();
    pstop = 1'b0;
    wdog_en = 1'b0;
    tick_en = 1'b0;
  endtask
  // fast wake from full stop, then leave self-clock mode through a check
  task automatic t_fast_wake;
    scm = 1'b1;
    self_clock_mode_enable = 1'b1;
    fwe = 1'b1;
    enter_stop();
    wake();
    chk(scm_act, 1'b1);
    chk(chk_act, 1'b0);
    chk(flag, 1'b0);
    cyc(12);
    chk(osc, 1'b0);
    chk(mon, 1'b0);
    chk(scm_act, 1'b1);
    fwe = 1'b0;
    cyc(2);
    chk(osc, 1'b1);
    chk(chk_act, 1'b1);
    for (int i = 0; i < 40 && flag !== 1'b1; i++) cyc(1);
    chk(flag, 1'b1);
    chk(scm_act, 1'b0);
    clear_flag();
    scm = 1'b0;
  endtask
  // full stop from self-clock without fast wake restarts the whole check
  task automatic t_full_scm;
    int n;
    scm = 1'b1;
    enter_stop();
    chk(chk_act, 1'b0);
    wake();
    chk(chk_act, 1'b1);
    for (n = 0; n < 40 && chk_act !== 1'b0; n++) cyc(1);
    chk(n >= 8, 1'b1); // a whole window of 8 good cycles was counted
    chk(flag, 1'b1);
    chk(sys, 1'b1);
    clear_flag();
    scm = 1'b0;
  endtask
  // pseudo stop from self-clock keeps the loop, regulator and check alive
  task automatic t_pseudo_scm;
    scm = 1'b1;
    pstop = 1'b1;
    enter_stop();
    chk(pll, 1'b1);
    chk(voltage_regulator, 1'b0);
    chk(chk_act, 1'b1);
    cyc(20);
    chk(sys, 1'b0);
    chk(chk_act, 1'b0);
    wake();
    chk(sys, 1'b1);
    clear_flag();
    scm = 1'b0;
    pstop = 1'b0;
  endtask
  // reset in full stop with fast wake armed takes the normal start-up
  task automatic t_reset_exit;
    scm = 1'b1;
    fwe = 1'b1;
    enter_stop();
    reset_n_in = 1'b0;
    cyc(1);
    reset_n_in = 1'b1;
    cyc(1);
    chk(scm_act, 1'b0);
    chk(osc, 1'b1);
    chk(sys, 1'b1);
    chk(sel, 1'b0);
    sel_set = 1'b1; // software selects the loop clock again, then drops it
    cyc(1);
    sel_set = 1'b0;
    chk(sel, 1'b1);
    sel_clr = 1'b1;
    cyc(1);
    sel_clr = 1'b0;
    chk(sel, 1'b0);
    fwe = 1'b0;
    scm = 1'b0;
  endtask
  // main sequence
  initial
  begin
    cyc(5);
    reset_n_in = 1'b1;
    cyc(1);
    chk(flag, smcs_pkg::RST_SCM_FLAG);
    chk(sel, smcs_pkg::RST_LOOP_SEL);
    t_full_stop();
    t_pseudo();
    t_fast_wake();
    t_full_scm();
    t_pseudo_scm();
    t_reset_exit();
    end_of_test();
  end
  // watchdog against a hang
  initial
  begin
    #50000;
    fails++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
